// file: hw/orbt_transceiver.sv
// Purpose: octal registered bus transceiver, normal-mode datapath
// Assumes: all pins synchronous to aclk; pin outputs lag inputs one cycle
// Notes:   output enables are low while the device drives the pin
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module orbt_transceiver import orbt_pkg::*; (
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// transceiver control pins
	input  wire logic              enable_n,
	input  wire logic              dir,
	input  wire logic              a_to_b_capture_clock,
	input  wire logic              b_to_a_capture_clock,
	input  wire logic              a_to_b_source_select,
	input  wire logic              b_to_a_source_select,
	// A bus pins
	input  wire logic [DATA_W-1:0] a_in,
	output logic      [DATA_W-1:0] a_out,
	output logic                   a_oe_n,
	// B bus pins
	input  wire logic [DATA_W-1:0] b_in,
	output logic      [DATA_W-1:0] b_out,
	output logic                   b_oe_n,
	// test logic boundary
	input  wire logic              test_mode,
	input  wire logic [DATA_W-1:0] test_a_out,
	input  wire logic              test_a_oe_n,
	input  wire logic [DATA_W-1:0] test_b_out,
	input  wire logic              test_b_oe_n,
	// capture log back-pressure
	output logic                   capture_log_ready,
	// AXI4-Lite write address
	input  wire logic [31:0]       s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [31:0]       s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);

	// ****************************************
	// declarations
	// ****************************************
	orbt_mode_type     mode;
	logic [DATA_W-1:0] store [2];
	logic [1:0]        cap_pulse;
	logic [DATA_W-1:0] bus_in [2];
	logic [1:0]        cap_clk;
	logic              drive_a;
	logic              drive_b;
	logic              log_en_r;
	logic [DROP_W-1:0] drop_r;
	logic [DROP_W-1:0] drop_nxt;
	logic [1:0]        dropped;
	logic              log_in_valid;
	orbt_log_type      log_in;
	orbt_log_type      log_out;
	logic              log_out_valid;
	logic              log_pop;
	logic              aw_hold_r;
	logic [ADDR_W-1:0] aw_addr_r;
	logic              w_hold_r;
	logic [31:0]       w_data_r;
	logic [3:0]        w_strb_r;
	logic              do_write;
	logic              clr_drop;
	logic [ADDR_W-1:0] rd_addr;
	logic [31:0]       rd_word;
	logic [1:0]        rd_resp;
	logic              ar_take;

	// ****************************************
	// pin decode
	// ****************************************

	// control pins bundled
	assign mode = '{enable_n, dir, a_to_b_source_select, b_to_a_source_select};

	// which side the device drives; sample-only test activity has no say
	assign drive_b = !mode.enable_n && mode.dir;
	assign drive_a = !mode.enable_n && !mode.dir;

	// ****************************************
	// storage registers, one per direction
	// ****************************************
	assign bus_in[SIDE_A]  = a_in;
	assign bus_in[SIDE_B]  = b_in;
	assign cap_clk[SIDE_A] = a_to_b_capture_clock;
	assign cap_clk[SIDE_B] = b_to_a_capture_clock;

	generate
		for (genvar s = 0; s < 2; s++) begin : g_dir
			orbt_capture u_capture (
				.aclk          (aclk),
				.aresetn       (aresetn),
				.capture_clock (cap_clk[s]),
				.suppress      (test_mode),
				.bus_in        (bus_in[s]),
				.stored        (store[s]),
				.capture_pulse (cap_pulse[s])
			);
		end
	endgenerate

	// ****************************************
	// pin drivers
	// ****************************************

	// B side: live or stored A data, or test logic
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			b_out  <= '0;
			b_oe_n <= 1'b1;
		end else if (test_mode) begin
			b_out  <= test_b_out;
			b_oe_n <= test_b_oe_n;
		end else begin
			b_out  <= mode.a_to_b_source_select ? store[SIDE_A] : a_in;
			b_oe_n <= !drive_b;
		end
	end

	// A side: live or stored B data, or test logic
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			a_out  <= '0;
			a_oe_n <= 1'b1;
		end else if (test_mode) begin
			a_out  <= test_a_out;
			a_oe_n <= test_a_oe_n;
		end else begin
			a_out  <= mode.b_to_a_source_select ? store[SIDE_B] : b_in;
			a_oe_n <= !drive_a;
		end
	end

	// ****************************************
	// capture log
	// ****************************************

	// A capture first; a second capture in the same cycle is dropped
	assign log_in_valid = log_en_r && (cap_pulse != 2'b00);
	assign log_in.side  = !cap_pulse[SIDE_A];
	assign log_in.data  = cap_pulse[SIDE_A] ? store_next(SIDE_A) : store_next(SIDE_B);

	function automatic logic [DATA_W-1:0] store_next(input int s);
		store_next = bus_in[s];
	endfunction : store_next

	orbt_fifo #(
		.WIDTH (LOG_W),
		.DEPTH (FIFO_DEPTH)
	) u_log (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (log_in_valid),
		.in_ready  (capture_log_ready),
		.in_data   (log_in),
		.out_valid (log_out_valid),
		.out_ready (log_pop),
		.out_data  (log_out)
	);

	// captures lost while logging is on: no room, or the second of two in one cycle
	always_comb begin
		dropped = 2'b00;
		if (log_en_r) begin
			dropped = 2'(cap_pulse[SIDE_A]) + 2'(cap_pulse[SIDE_B]);
			if (log_in_valid && capture_log_ready) begin
				dropped = dropped - 2'b01;
			end
		end
	end

	// saturating drop counter; a new drop wins over the clear
	always_comb begin
		drop_nxt = clr_drop ? '0 : drop_r;
		if (drop_nxt > {DROP_W{1'b1}} - DROP_W'(dropped)) begin
			drop_nxt = {DROP_W{1'b1}};
		end else begin
			drop_nxt = drop_nxt + DROP_W'(dropped);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			drop_r <= '0;
		end else begin
			drop_r <= drop_nxt;
		end
	end

	// ****************************************
	// AXI4-Lite write side
	// ****************************************
	assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
	assign do_write      = aw_hold_r && w_hold_r && !s_axi_bvalid;
	assign clr_drop      = do_write && aw_addr_r == ADDR_CTRL && w_strb_r[0]
		&& w_data_r[CTRL_CLR_DROP_BIT];

	// address and data latches, taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			aw_addr_r <= '0;
			w_hold_r  <= 1'b0;
			w_data_r  <= '0;
			w_strb_r  <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr[ADDR_W-1:0];
			end else if (do_write) begin
				aw_hold_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (do_write) begin
				w_hold_r <= 1'b0;
			end
		end
	end

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (aw_addr_r == ADDR_CTRL) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// control register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			log_en_r <= CTRL_LOG_EN_RST;
		end else if (do_write && aw_addr_r == ADDR_CTRL && w_strb_r[0]) begin
			log_en_r <= w_data_r[CTRL_LOG_EN_BIT];
		end
	end

	// ****************************************
	// AXI4-Lite read side
	// ****************************************
	assign s_axi_arready = !s_axi_rvalid;
	assign ar_take       = s_axi_arvalid && s_axi_arready;
	assign rd_addr       = s_axi_araddr[ADDR_W-1:0];
	assign log_pop       = ar_take && rd_addr == ADDR_LOG;

	// read mux
	always_comb begin
		rd_word = '0;
		rd_resp = RESP_OKAY;
		case (rd_addr)
			ADDR_CTRL: begin
				rd_word[CTRL_LOG_EN_BIT] = log_en_r;
			end
			ADDR_STATUS: begin
				rd_word[DROP_W-1:0]      = drop_r;
				rd_word[ST_NONEMPTY_BIT] = log_out_valid;
				rd_word[ST_FULL_BIT]     = !capture_log_ready;
				rd_word[ST_A_DRIVE_BIT]  = !a_oe_n;
				rd_word[ST_B_DRIVE_BIT]  = !b_oe_n;
				rd_word[ST_TEST_BIT]     = test_mode;
			end
			ADDR_STORE: begin
				rd_word[DATA_W-1:0]        = store[SIDE_A];
				rd_word[2*DATA_W-1:DATA_W] = store[SIDE_B];
			end
			ADDR_LOG: begin
				rd_word[LOG_W-1:0]    = log_out;
				rd_word[LOG_VALID_BIT] = log_out_valid;
			end
			default: begin
				rd_resp = RESP_SLVERR;
			end
		endcase
	end

	// read response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (ar_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_resp;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	a_drive_a_to_b: assert property (@(posedge aclk) disable iff (!aresetn)
		!test_mode && !enable_n && dir |=> !b_oe_n && a_oe_n)
		else $error("B not driven for A to B transfer");
	a_drive_b_to_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!test_mode && !enable_n && !dir |=> !a_oe_n && b_oe_n)
		else $error("A not driven for B to A transfer");
	a_bus_isolation: assert property (@(posedge aclk) disable iff (!aresetn)
		!test_mode && enable_n |=> a_oe_n && b_oe_n)
		else $error("a bus driven while disabled");
	a_transparent_ab: assert property (@(posedge aclk) disable iff (!aresetn)
		!test_mode && !a_to_b_source_select |=> b_out == $past(a_in))
		else $error("B does not show live A data");
	a_registered_ab: assert property (@(posedge aclk) disable iff (!aresetn)
		!test_mode && a_to_b_source_select |=> b_out == $past(store[SIDE_A]))
		else $error("B does not show stored A data");
	a_mirror_ba: assert property (@(posedge aclk) disable iff (!aresetn)
		!test_mode |=> a_out == ($past(b_to_a_source_select)
			? $past(store[SIDE_B]) : $past(b_in)))
		else $error("A side path wrong");
	a_capture_any: assert property (@(posedge aclk) disable iff (!aresetn)
		!test_mode && enable_n && a_to_b_capture_clock
			##1 !a_to_b_capture_clock ##1 a_to_b_capture_clock && !test_mode
		|=> store[SIDE_A] == $past(a_in))
		else $error("capture lost while outputs disabled");
	a_test_inhibit: assert property (@(posedge aclk) disable iff (!aresetn)
		test_mode |-> !cap_pulse[SIDE_A] && !cap_pulse[SIDE_B]
			##1 a_oe_n == $past(test_a_oe_n) && b_out == $past(test_b_out))
		else $error("normal operation not inhibited in test mode");

endmodule : orbt_transceiver

// file: hw/orbt_pkg.sv
// Purpose: constants and types of the octal registered bus transceiver
// Assumes: one clock aclk, synchronous active-low reset aresetn
// Notes:   register map reached over AXI4-Lite, one 32-bit word each
//
// Overview of operation
// - enable low and direction high drives the B bus from the A side path.
// - enable low and direction low drives the A bus from the B side path.
// - enable high releases both buses whatever the direction says.
// - each rising capture edge from A to B stores the A bus in the A store.
// - select low from A to B shows live A data on the driven B bus.
// - select high from A to B shows the stored A data on the driven B bus.
// - the B to A capture clock and select mirror the A to B pair.
// - capture happens on every edge, whatever enable and direction say.
// - a value captured from a pin the device drives itself is unspecified.
// - test mode stops normal operation and hands the pins to test logic.
// - sample-only test activity leaves normal behaviour untouched.

package orbt_pkg;

	// ****************************************
	// widths and depths
	// ****************************************
	localparam int DATA_W     = 8;
	localparam int FIFO_DEPTH = 4;
	localparam int ADDR_W     = 4;
	localparam int DROP_W     = 8;

	// ****************************************
	// register offsets and fields
	// ****************************************
	localparam logic [ADDR_W-1:0] ADDR_CTRL   = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_STORE  = 4'h8;
	localparam logic [ADDR_W-1:0] ADDR_LOG    = 4'hC;
	localparam int CTRL_LOG_EN_BIT   = 0;
	localparam int CTRL_CLR_DROP_BIT = 1;
	localparam logic CTRL_LOG_EN_RST = 1'h1;
	localparam int ST_NONEMPTY_BIT = 8;
	localparam int ST_FULL_BIT     = 9;
	localparam int ST_A_DRIVE_BIT  = 10;
	localparam int ST_B_DRIVE_BIT  = 11;
	localparam int ST_TEST_BIT     = 12;
	localparam int LOG_VALID_BIT   = 31;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int SIDE_A = 0;
	localparam int SIDE_B = 1;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic enable_n;
		logic dir;
		logic a_to_b_source_select;
		logic b_to_a_source_select;
	} orbt_mode_type;

	typedef struct packed {
		logic              side;
		logic [DATA_W-1:0] data;
	} orbt_log_type;

	localparam int LOG_W = $bits(orbt_log_type);

endpackage : orbt_pkg

// file: hw/orbt_capture.sv
// Purpose: one direction's storage register with capture edge detect
// Assumes: capture clock input is synchronous to aclk
// Notes:   the store itself has no reset
`timescale 1ns/1ps
module orbt_capture import orbt_pkg::*; (
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// capture control
	input  wire logic              capture_clock,
	input  wire logic              suppress,
	input  wire logic [DATA_W-1:0] bus_in,
	// result
	output logic      [DATA_W-1:0] stored,
	output logic                   capture_pulse
);
	logic clk_prev_r;

	// previous capture clock level
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_prev_r <= 1'b0;
		end else begin
			clk_prev_r <= capture_clock;
		end
	end

	// rising capture edge, ignored in test mode
	assign capture_pulse = capture_clock && !clk_prev_r && !suppress;

	// storage with no reset; pin value taken as seen, even if self-driven
	always_ff @(posedge aclk) begin
		if (capture_pulse) begin
			stored <= bus_in;
		end
	end

	a_capture_loads: assert property (@(posedge aclk) disable iff (!aresetn)
		capture_pulse |=> stored == $past(bus_in))
		else $error("store did not load on capture edge");
	a_store_holds: assert property (@(posedge aclk) disable iff (!aresetn)
		!capture_pulse |=> stored === $past(stored))
		else $error("store changed without capture edge");

endmodule : orbt_capture

// file: hw/orbt_fifo.sv
// Purpose: small capture log FIFO, valid and ready on both sides
// Assumes: one clock, synchronous reset
// Notes:   depth is a power of two
`timescale 1ns/1ps
module orbt_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr_r;
	logic [PW-1:0]    rd_ptr_r;
	logic [PW:0]      count_r;
	logic             push;
	logic             pop;

	// handshakes
	assign in_ready  = count_r != DEPTH[PW:0];
	assign out_valid = count_r != '0;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr_r];

	// storage
	always_ff @(posedge aclk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	// pointers and fill count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_r + PW'(push);
			rd_ptr_r <= rd_ptr_r + PW'(pop);
			count_r  <= count_r + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	a_fifo_bound: assert property (@(posedge aclk) disable iff (!aresetn)
		count_r <= DEPTH[PW:0])
		else $error("fifo count beyond depth");

endmodule : orbt_fifo

// file: tb/orbt_bus_model.sv
// Purpose: far side of one 8-bit bus, resolves the wire level
// Assumes: device drive wins over the far side driver
// Notes:   a bus nobody drives shows the inverse of its last level
`timescale 1ns/1ps
module orbt_bus_model import orbt_pkg::*; (
	// clock
	input  wire logic              aclk,
	// device side of the pin
	input  wire logic [DATA_W-1:0] dev_out,
	input  wire logic              dev_oe_n,
	// far side driver
	input  wire logic              far_drive,
	input  wire logic [DATA_W-1:0] far_data,
	// resolved wire
	output logic      [DATA_W-1:0] level
);
	logic [DATA_W-1:0] last_r = 8'h00;

	// ****************************************
	// wire resolution
	// ****************************************
	// released wire floats, so never repeat the old level
	always_comb begin
		if (!dev_oe_n)
			level = dev_out;
		else if (far_drive)
			level = far_data;
		else
			level = ~last_r;
	end

	// remember the level for the floating pattern
	always @(posedge aclk) begin
		last_r <= level;
	end
endmodule : orbt_bus_model

// file: tb/orbt_transceiver_tb.sv
// Purpose: self-checking bench of the registered bus transceiver
// Assumes: pins registered one cycle, stores visible one edge later
// Notes:   a reference model beside the pins predicts every edge
`timescale 1ns/1ps
module orbt_transceiver_tb import orbt_pkg::*;;
	logic aclk = 0, aresetn = 0, enable_n = 1, dir = 0, cab = 0, cba = 0;
	logic sel_ab = 0, sel_ba = 0, test_mode = 0, ta_oe_n = 1, tb_oe_n = 1, fa_en = 1, fb_en = 1;
	logic [7:0] a_in, b_in, a_out, b_out, ta_d = 0, tb_d = 0, fa_d = 0, fb_d = 0;
	logic a_oe_n, b_oe_n, capture_log_ready;
	logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [31:0] rd;
	logic [7:0] sa, sb, ea, eb;
	logic ea_oe_n, eb_oe_n, pa, pb;
	int failures = 0, check_count = 0, rnd;

	always #2.5 aclk = ~aclk;

	orbt_transceiver i_dut (.aclk, .aresetn, .enable_n, .dir,
		.a_to_b_capture_clock(cab), .b_to_a_capture_clock(cba),
		.a_to_b_source_select(sel_ab), .b_to_a_source_select(sel_ba),
		.a_in, .a_out, .a_oe_n, .b_in, .b_out, .b_oe_n, .test_mode,
		.test_a_out(ta_d), .test_a_oe_n(ta_oe_n),
		.test_b_out(tb_d), .test_b_oe_n(tb_oe_n),
		.capture_log_ready, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	orbt_bus_model i_bus_a (.aclk, .dev_out(a_out), .dev_oe_n(a_oe_n),
		.far_drive(fa_en), .far_data(fa_d), .level(a_in));
	orbt_bus_model i_bus_b (.aclk, .dev_out(b_out), .dev_oe_n(b_oe_n),
		.far_drive(fb_en), .far_data(fb_d), .level(b_in));

	// ****************************************
	// checks and closing
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : print_verdict

	// expected pin data: stored or live value
	function automatic logic [7:0] exp_pin(input logic sel, input logic [7:0] st,
		input logic [7:0] live);
		exp_pin = sel ? st : live;
	endfunction : exp_pin

	// expected log word for one entry
	function automatic logic [31:0] exp_log(input logic side, input logic [7:0] data);
		exp_log = 32'h0;
		exp_log[LOG_VALID_BIT] = 1'b1;
		exp_log[DATA_W] = side;
		exp_log[DATA_W-1:0] = data;
	endfunction : exp_log

	// expected status word with no pin driven
	function automatic logic [31:0] exp_status(input logic [7:0] drops,
		input logic nonempty, input logic full);
		exp_status = 32'h0;
		exp_status[DROP_W-1:0] = drops;
		exp_status[ST_NONEMPTY_BIT] = nonempty;
		exp_status[ST_FULL_BIT] = full;
	endfunction : exp_status

	// reference model of the pins, sampled on the same edge as the design
	always @(posedge aclk) begin
		if (!aresetn) begin
			{ea_oe_n, eb_oe_n, pa, pb} = 4'hC;
		end else if (test_mode) begin
			{ea, ea_oe_n, eb, eb_oe_n} = {ta_d, ta_oe_n, tb_d, tb_oe_n};
			{pa, pb} = {cab, cba};
		end else begin
			eb = exp_pin(sel_ab, sa, a_in);
			ea = exp_pin(sel_ba, sb, b_in);
			eb_oe_n = !(!enable_n && dir);
			ea_oe_n = !(!enable_n && !dir);
			if (cab && !pa) sa = a_in;
			if (cba && !pb) sb = b_in;
			{pa, pb} = {cab, cba};
		end
		#1;
		chk(a_oe_n, ea_oe_n);
		chk(b_oe_n, eb_oe_n);
		if (!ea_oe_n) chk(a_out, ea);
		if (!eb_oe_n) chk(b_out, eb);
	end

	// ****************************************
	// bus tasks
	// ****************************************
	task automatic axi_wr(input logic [31:0] ad, input logic [31:0] dt);
		logic ta, tw;
		@(posedge aclk);
		s_axi_awaddr <= ad;
		s_axi_awvalid <= 1;
		s_axi_wdata <= dt;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		#1;
		while (s_axi_awvalid || s_axi_wvalid) begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
			#1;
		end
		do begin
			@(negedge aclk);
			ta = s_axi_bvalid;
			rs = s_axi_bresp;
			@(posedge aclk);
		end while (!ta);
		s_axi_bready <= 0;
	endtask : axi_wr

	task automatic axi_rd(input logic [31:0] ad);
		logic got;
		@(posedge aclk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(negedge aclk);
			got = s_axi_arready;
			@(posedge aclk);
		end while (!got);
		s_axi_arvalid <= 0;
		do begin
			@(negedge aclk);
			got = s_axi_rvalid;
			rd = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge aclk);
		end while (!got);
		s_axi_rready <= 0;
	endtask : axi_rd

	// one capture pulse with the far side driving the value
	task automatic cap_pulse(input logic sd, input logic [7:0] v);
		@(posedge aclk);
		if (sd) begin
			fb_d <= v;
			cba <= 1;
		end else begin
			fa_d <= v;
			cab <= 1;
		end
		@(posedge aclk);
		cab <= 0;
		cba <= 0;
	endtask : cap_pulse

	// ****************************************
	// tests
	// ****************************************
	initial begin
		#20000;
		failures++;
		print_verdict();
	end

	initial begin
		rnd = $urandom(32'hF42201F0);
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		axi_rd({28'h0, ADDR_CTRL});
		chk(rd, 32'h1);
		// fill the log until it refuses, one entry dropped
		cap_pulse(1, 8'h3C);
		for (int k = 0; k < 4; k++) cap_pulse(0, 8'(8'h10 * k + 8'h01));
		@(posedge aclk);
		#1;
		chk(capture_log_ready, 1'b0);
		axi_rd({28'h0, ADDR_STATUS});
		chk(rd, exp_status(8'h01, 1'b1, 1'b1));
		axi_rd({28'h0, ADDR_STORE});
		chk(rd, 32'h3C31);
		for (int k = 0; k < 4; k++) begin
			axi_rd({28'h0, ADDR_LOG});
			if (k == 0)
				chk(rd, exp_log(1'b1, 8'h3C));
			else
				chk(rd, exp_log(1'b0, 8'(8'h10 * (k - 1) + 8'h01)));
		end
		axi_rd({28'h0, ADDR_LOG});
		chk(rd[LOG_VALID_BIT], 1'b0);
		#1;
		chk(capture_log_ready, 1'b1);
		axi_wr({28'h0, ADDR_CTRL}, 32'h3);
		chk(rs, RESP_OKAY);
		axi_rd({28'h0, ADDR_STATUS});
		chk(rd, 32'h0);
		axi_wr({28'h0, ADDR_STATUS}, 32'h0);
		chk(rs, RESP_SLVERR);
		axi_rd(32'h2);
		chk(rs, RESP_SLVERR);
		chk(rd, 32'h0);
		axi_wr({28'h0, ADDR_CTRL}, 32'h0);
		cap_pulse(0, 8'h77);
		axi_rd({28'h0, ADDR_STATUS});
		chk(rd, 32'h0);
		axi_rd({28'h0, ADDR_STORE});
		chk(rd[7:0], 8'h77);
		// random pins with a test-mode stretch in the middle
		for (int i = 0; i < 80; i++) begin
			@(posedge aclk);
			rnd = $urandom();
			{enable_n, dir, sel_ab, sel_ba, fa_en, fb_en} <= rnd[5:0];
			{cab, cba} <= ((i >= 39 && i <= 41) || (i >= 48 && i <= 51)) ? 2'b0 : rnd[7:6];
			{fa_d, fb_d, ta_d, tb_d} <= {rnd[15:8], rnd[23:16], rnd[31:24], rnd[15:8]};
			{ta_oe_n, tb_oe_n} <= rnd[9:8];
			test_mode <= (i >= 40 && i < 50);
		end
		repeat (3) @(posedge aclk);
		print_verdict();
	end
endmodule : orbt_transceiver_tb
